// File: rtl/tmr_regs.vh
// Constants and the operating overview for the 8-bit single compare timer core
// Overview of operation
// - Counter, compare value and comparator are all 8 bits wide.
// - Tick comes from prescaled internal clock or external pin, edge selectable.
// - Clock select zero gives no tick; counter stays stopped.
// - Each tick clears, increments or decrements counter; top and bottom are signalled.
// - Processor may read and write the counter at any time.
// - Processor counter write beats any clear or count that cycle.
// - Two-bit wave mode field sets count sequence and overflow conditions.
// - Overflow flag requests interrupt through its own mask bit and the global interrupt enable.
// - Comparator runs always; equality sets compare flag on next tick.
// - Compare interrupt needs enable bit and global interrupt enable both set.
// - Compare flag clears on interrupt service or on writing one.
// - Compare value double buffered in PWM modes, direct in normal and CTC.
// - Buffered compare value loads into active register only at top (0xFF), in both PWM modes.
// - Compare accesses target buffer when buffering, active register otherwise.
// - Force compare in non-PWM modes acts on output only, no flag, no clear.
// - Counter write blocks compare matches in next tick, even when stopped.
// - Wave output register keeps its value across wave mode changes.
// - Output action field sets next match action and pin source, unbuffered.
// - System reset clears the wave output register.
// - Mode 0 counts up, wraps 0xFF to zero, overflow flag on wrap.
// - Mode 2 clears counter on compare match.
// - Mode 3 counts single slope zero to max and restarts.
`ifndef TMR_REGS_VH
`define TMR_REGS_VH
`define TMR_WIDTH        8
`define TMR_MAX          8'hFF
`define TMR_BOTTOM       8'h00
`define TMR_CNT_RST      8'h00
`define TMR_CMP_RST      8'h00
`define TMR_MODE_NORMAL  2'h0
`define TMR_MODE_PCPWM   2'h1
`define TMR_MODE_CTC     2'h2
`define TMR_MODE_FPWM    2'h3
`define TMR_ACT_NONE     2'h0
`define TMR_ACT_TOGGLE   2'h1
`define TMR_ACT_CLEAR    2'h2
`define TMR_ACT_SET      2'h3
`define TMR_CS_STOP      3'h0
`define TMR_CS_DIV1      3'h1
`define TMR_CS_DIV8      3'h2
`define TMR_CS_DIV64     3'h3
`define TMR_CS_DIV256    3'h4
`define TMR_CS_DIV1024   3'h5
`define TMR_CS_EXT_FALL  3'h6
`define TMR_CS_EXT_RISE  3'h7
`define TMR_PRE_WIDTH    10
`endif

// File: rtl/tmr_tick_sel.v
// Timer tick source: prescaler and external count pin edge detector
`timescale 1ns/1ps
`include "tmr_regs.vh"
module tmr_tick_sel (
	input  wire       mclk,
	input  wire       rst,
	input  wire [2:0] clock_select,
	input  wire       ext_count_pin,
	output reg        timer_tick
);
	reg  [`TMR_PRE_WIDTH-1:0] pre_r;
	reg  [2:0]                sync_r;
	reg                       tick_nxt;
	wire [`TMR_PRE_WIDTH-1:0] pre_inc;

	assign pre_inc = pre_r + {{(`TMR_PRE_WIDTH-1){1'b0}}, 1'b1};

	always @(posedge mclk) begin
		if (rst) begin
			pre_r  <= {`TMR_PRE_WIDTH{1'b0}};
			sync_r <= 3'h0;
		end else begin
			pre_r  <= pre_inc;
			sync_r <= {sync_r[1:0], ext_count_pin};
		end
	end

	// Stage 0 is only read by stage 1; the edge is taken from stages 1 and 2
	always @* begin
		case (clock_select)
			`TMR_CS_STOP:     tick_nxt = 1'b0;
			`TMR_CS_DIV1:     tick_nxt = 1'b1;
			`TMR_CS_DIV8:     tick_nxt = (pre_r[2:0] == 3'h7);
			`TMR_CS_DIV64:    tick_nxt = (pre_r[5:0] == 6'h3F);
			`TMR_CS_DIV256:   tick_nxt = (pre_r[7:0] == 8'hFF);
			`TMR_CS_DIV1024:  tick_nxt = (pre_r == 10'h3FF);
			`TMR_CS_EXT_FALL: tick_nxt = sync_r[2] & ~sync_r[1];
			default:          tick_nxt = ~sync_r[2] & sync_r[1];
		endcase
	end

	always @(posedge mclk) begin
		if (rst)
			timer_tick <= 1'b0;
		else
			timer_tick <= tick_nxt;
	end
endmodule // tmr_tick_sel

// File: rtl/tmr_core.v
// Top of the 8-bit single compare timer/counter core
`timescale 1ns/1ps
`include "tmr_regs.vh"
module tmr_core (
	input  wire       mclk,
	input  wire       rst,
	input  wire [2:0] clock_select,
	input  wire [1:0] wave_mode_sel,
	input  wire [1:0] output_action_sel,
	input  wire       ext_count_pin,
	input  wire       count_wr,
	input  wire [7:0] count_wdata,
	input  wire       compare_wr,
	input  wire [7:0] compare_wdata,
	input  wire       force_compare,
	input  wire       compare_flag_clr,
	input  wire       overflow_flag_clr,
	input  wire       compare_irq_ack,
	input  wire       overflow_irq_ack,
	input  wire       compare_irq_enable,
	input  wire       overflow_irq_enable,
	input  wire       global_irq_enable,
	output reg  [7:0] count_value,
	output reg  [7:0] compare_value,
	output reg  [7:0] compare_active,
	output reg        compare_flag,
	output reg        overflow_flag,
	output reg        compare_irq,
	output reg        overflow_irq,
	output reg        wave_output,
	output reg        wave_pin_sel,
	output reg        at_top,
	output reg        at_bottom
);
	wire       timer_tick;
	reg  [7:0] cnt_nxt;
	reg        dir_down_r;
	reg        dir_nxt;
	reg        block_r;
	reg  [7:0] ocr_act_r;
	reg  [7:0] ocr_buf_r;
	reg  [7:0] ocr_act_nxt;
	reg        wave_r;
	reg        wave_nxt;
	reg        ovf_set;
	reg        match_pend_r;
	wire       pwm_mode;
	wire       match;
	wire       match_used;
	wire       ocf_nxt;
	wire       tov_nxt;

	function [7:0] step8;
		input [7:0] v;
		input       down;
		begin
			if (down)
				step8 = v - 8'h01;
			else
				step8 = v + 8'h01;
		end
	endfunction

	// Action taken on the output at a compare event, per current action field
	function act_wave;
		input [1:0] act;
		input       cur;
		begin
			case (act)
				`TMR_ACT_TOGGLE: act_wave = ~cur;
				`TMR_ACT_CLEAR:  act_wave = 1'b0;
				`TMR_ACT_SET:    act_wave = 1'b1;
				default:         act_wave = cur;
			endcase
		end
	endfunction

	tmr_tick_sel u_tick (
		.mclk          (mclk),
		.rst           (rst),
		.clock_select  (clock_select),
		.ext_count_pin (ext_count_pin),
		.timer_tick    (timer_tick)
	);

	assign pwm_mode   = wave_mode_sel[0];
	assign match      = (count_value == ocr_act_r);
	assign match_used = timer_tick & match & ~block_r;

	// Counting sequence per wave mode
	always @* begin
		cnt_nxt = count_value;
		dir_nxt = dir_down_r;
		ovf_set = 1'b0;
		if (timer_tick) begin
			case (wave_mode_sel)
				`TMR_MODE_NORMAL: begin
					cnt_nxt = step8(count_value, 1'b0);
					ovf_set = (count_value == `TMR_MAX);
					dir_nxt = 1'b0;
				end
				`TMR_MODE_CTC: begin
					dir_nxt = 1'b0;
					ovf_set = (count_value == `TMR_MAX);
					if (match & ~block_r)
						cnt_nxt = `TMR_BOTTOM;
					else
						cnt_nxt = step8(count_value, 1'b0);
				end
				`TMR_MODE_FPWM: begin
					dir_nxt = 1'b0;
					ovf_set = (count_value == `TMR_MAX);
					if (count_value == `TMR_MAX)
						cnt_nxt = `TMR_BOTTOM;
					else
						cnt_nxt = step8(count_value, 1'b0);
				end
				default: begin
					// Dual slope: turn at max and at bottom; overflow at bottom
					if (count_value == `TMR_MAX)
						dir_nxt = 1'b1;
					else if (count_value == `TMR_BOTTOM)
						dir_nxt = 1'b0;
					cnt_nxt = step8(count_value, dir_nxt);
					ovf_set = (count_value == `TMR_BOTTOM);
				end
			endcase
		end
		if (count_wr)
			cnt_nxt = count_wdata;
	end

	// Active compare register: direct in non-PWM, loaded from buffer at top in both PWM modes
	always @* begin
		ocr_act_nxt = ocr_act_r;
		if (!pwm_mode) begin
			if (compare_wr)
				ocr_act_nxt = compare_wdata;
		end else if (timer_tick) begin
			if (wave_mode_sel == `TMR_MODE_PCPWM && count_value == `TMR_MAX)
				ocr_act_nxt = ocr_buf_r;
			else if (wave_mode_sel == `TMR_MODE_FPWM && count_value == `TMR_MAX)
				ocr_act_nxt = ocr_buf_r;
		end
	end

	// Output register; untouched by mode changes, only events move it
	always @* begin
		wave_nxt = wave_r;
		if (!pwm_mode) begin
			if (match_used | force_compare)
				wave_nxt = act_wave(output_action_sel, wave_r);
		end else if (output_action_sel[1]) begin
			if (wave_mode_sel == `TMR_MODE_FPWM) begin
				if (match_used)
					wave_nxt = output_action_sel[0];
				else if (timer_tick && count_value == `TMR_MAX)
					wave_nxt = ~output_action_sel[0];
			end else if (match_used) begin
				// Phase correct: up-match applies the field's clear/set, down-match the opposite
				wave_nxt = output_action_sel[0] ^ dir_down_r;
			end
		end
	end

	// Match flag lands on the tick after the comparator saw equality
	assign ocf_nxt = match_pend_r & timer_tick;
	assign tov_nxt = ovf_set & ~count_wr;

	always @(posedge mclk) begin
		if (rst) begin
			count_value    <= `TMR_CNT_RST;
			dir_down_r     <= 1'b0;
			block_r        <= 1'b0;
			ocr_act_r      <= `TMR_CMP_RST;
			ocr_buf_r      <= `TMR_CMP_RST;
			wave_r         <= 1'b0;
			match_pend_r   <= 1'b0;
			compare_flag   <= 1'b0;
			overflow_flag  <= 1'b0;
		end else begin
			count_value <= cnt_nxt;
			dir_down_r  <= dir_nxt;
			// Write arms the block; it lasts until one tick has been consumed
			if (count_wr)
				block_r <= 1'b1;
			else if (timer_tick)
				block_r <= 1'b0;
			ocr_act_r <= ocr_act_nxt;
			if (compare_wr)
				ocr_buf_r <= compare_wdata;
			wave_r <= wave_nxt;
			if (match_used)
				match_pend_r <= 1'b1;
			else if (timer_tick)
				match_pend_r <= 1'b0;
			// Hardware set wins over a clear arriving in the same cycle
			if (ocf_nxt)
				compare_flag <= 1'b1;
			else if (compare_flag_clr | compare_irq_ack)
				compare_flag <= 1'b0;
			if (tov_nxt)
				overflow_flag <= 1'b1;
			else if (overflow_flag_clr | overflow_irq_ack)
				overflow_flag <= 1'b0;
		end
	end

	// Registered views for the outputs
	always @(posedge mclk) begin
		if (rst) begin
			compare_value  <= `TMR_CMP_RST;
			compare_active <= `TMR_CMP_RST;
			compare_irq    <= 1'b0;
			overflow_irq   <= 1'b0;
			wave_output    <= 1'b0;
			wave_pin_sel   <= 1'b0;
			at_top         <= 1'b0;
			at_bottom      <= 1'b0;
		end else begin
			compare_value  <= pwm_mode ? ocr_buf_r : ocr_act_r;
			compare_active <= ocr_act_r;
			compare_irq    <= compare_flag & compare_irq_enable & global_irq_enable;
			overflow_irq   <= overflow_flag & overflow_irq_enable & global_irq_enable;
			wave_output    <= wave_r;
			wave_pin_sel   <= (output_action_sel != `TMR_ACT_NONE);
			at_top         <= (count_value == `TMR_MAX);
			at_bottom      <= (count_value == `TMR_BOTTOM);
		end
	end
endmodule // tmr_core

// File: sim/tmr_core_monitor.sv
// Port-level concurrent checks for the timer core
`timescale 1ns/1ps
module tmr_core_mon (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic [2:0] clock_select,
	input wire logic [1:0] wave_mode_sel,
	input wire logic [1:0] output_action_sel,
	input wire logic       count_wr,
	input wire logic [7:0] count_wdata,
	input wire logic       force_compare,
	input wire logic       compare_flag_clr,
	input wire logic       compare_irq_ack,
	input wire logic       compare_irq_enable,
	input wire logic       global_irq_enable,
	input wire logic [7:0] count_value,
	input wire logic       compare_flag,
	input wire logic       overflow_flag,
	input wire logic       compare_irq,
	input wire logic       wave_output,
	input wire logic       wave_pin_sel,
	input wire logic       at_top
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Tick is registered from the select, so two stopped samples mean no tick
	sequence s_stopped;
		clock_select == 3'h0 && $past(clock_select) == 3'h0;
	endsequence
	sequence s_force_set;
		force_compare && wave_mode_sel == 2'h0 && output_action_sel == 2'h3 && !compare_flag;
	endsequence
	a_stop_holds: assert property (s_stopped ##0 !count_wr |=> $stable(count_value))
		else $error("counter moved while stopped");
	a_write_loads: assert property (count_wr |=> count_value == $past(count_wdata))
		else $error("counter write lost");
	a_reset_clear: assert property (@(posedge mclk) disable iff (1'b0) rst |=> !wave_output && !compare_flag)
		else $error("reset left output set");
	a_irq_gate: assert property (compare_irq == $past(compare_flag && compare_irq_enable && global_irq_enable))
		else $error("compare irq gating wrong");
	a_flag_wclr: assert property (s_stopped ##0 (compare_flag_clr || compare_irq_ack) |=> !compare_flag)
		else $error("compare flag not cleared");
	a_force_out: assert property (s_stopped ##0 s_force_set |=> !compare_flag ##[0:1] wave_output)
		else $error("forced compare wrong");
	a_wrap_ovf: assert property ($past(count_value) == 8'hFF && count_value == 8'h00 && wave_mode_sel == 2'h0
		&& $past(wave_mode_sel) == 2'h0 && !$past(count_wr) |-> overflow_flag)
		else $error("wrap without overflow flag");
	a_pin_source: assert property (wave_pin_sel == ($past(output_action_sel) != 2'h0))
		else $error("pin source select wrong");
	a_top_mark: assert property (at_top == ($past(count_value) == 8'hFF))
		else $error("top mark wrong");
endmodule // tmr_core_mon

// File: sim/tmr_tb.sv
// Self-checking bench for the timer core
`timescale 1ns/1ps
`define CHK(n, e, a) begin #1; cmp_count++; if ((a) !== (e)) begin error_cnt++; \
	$display("MISMATCH %s exp %h got %h", n, e, a); end end
module testbench;
	logic       mclk, rst, gie, cie, oie, ext;
	logic [2:0] cs;
	logic [1:0] wm, act;
	logic [6:0] strb;
	logic [7:0] cnt_d, cmp_d;
	wire  [7:0] count_value, compare_value, compare_active;
	wire        compare_flag, overflow_flag, compare_irq, overflow_irq, wave_output, wave_pin_sel, at_top;
	wire        at_bottom;
	int         error_cnt, cmp_count, cyc;
	tmr_core dut (.mclk(mclk), .rst(rst), .clock_select(cs), .wave_mode_sel(wm), .output_action_sel(act),
		.ext_count_pin(ext), .count_wr(strb[6]), .count_wdata(cnt_d), .compare_wr(strb[5]),
		.compare_wdata(cmp_d), .force_compare(strb[4]), .compare_flag_clr(strb[3]),
		.overflow_flag_clr(strb[2]), .compare_irq_ack(strb[1]), .overflow_irq_ack(strb[0]),
		.compare_irq_enable(cie), .overflow_irq_enable(oie), .global_irq_enable(gie),
		.count_value(count_value), .compare_value(compare_value), .compare_active(compare_active),
		.compare_flag(compare_flag), .overflow_flag(overflow_flag), .compare_irq(compare_irq),
		.overflow_irq(overflow_irq), .wave_output(wave_output), .wave_pin_sel(wave_pin_sel),
		.at_top(at_top), .at_bottom(at_bottom));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic pulse(input [6:0] m);
		@(posedge mclk);
		strb <= m;
		@(posedge mclk);
		strb <= 7'h00;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// Each level lasts four cycles so the three-stage synchroniser sees it
	task automatic ext_edges(input int n);
		repeat (n) begin
			ext <= 1'b1;
			tick(4);
			ext <= 1'b0;
			tick(4);
		end
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Hang guard well above the few hundred cycles the tests need
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			give_verdict;
		end
	end
	initial begin
		{rst, gie, cie, oie, ext, cs, wm, act, strb, cnt_d, cmp_d} = '0;
		rst = 1'b1;
		tick(3);
		rst <= 1'b0;
		`CHK("wave_output", 1'b0, wave_output)
		tick(1);
		`CHK("at_bottom", 1'b1, at_bottom)
		cnt_d <= 8'h10;
		pulse(7'h40);
		tick(5);
		`CHK("count stopped", 8'h10, count_value)
		$display("test stop done");
		wm <= 2'h2;
		cmp_d <= 8'h05;
		cnt_d <= 8'h00;
		pulse(7'h60);
		cs <= 3'h1;
		for (int i = 0; i < 40 && compare_flag !== 1'b1; i++) @(posedge mclk);
		`CHK("ctc flag", 1'b1, compare_flag)
		tick(20);
		`CHK("ctc bound", 1'b1, count_value <= 8'h05)
		cs <= 3'h0;
		{cie, gie} <= 2'b11;
		tick(3);
		`CHK("irq on", 1'b1, compare_irq)
		gie <= 1'b0;
		tick(2);
		`CHK("irq masked", 1'b0, compare_irq)
		pulse(7'h02);
		`CHK("ack clears", 1'b0, compare_flag)
		$display("test ctc done");
		wm <= 2'h0;
		cnt_d <= 8'hFE;
		pulse(7'h48);
		cs <= 3'h1;
		for (int i = 0; i < 40 && overflow_flag !== 1'b1; i++) @(posedge mclk);
		`CHK("wrap", 1'b1, count_value < 8'h03)
		`CHK("wrap flag", 1'b1, overflow_flag)
		cs <= 3'h0;
		act <= 2'h3;
		{oie, gie} <= 2'b11;
		tick(4);
		`CHK("ovf irq", 1'b1, overflow_irq)
		pulse(7'h1C);
		tick(2);
		`CHK("force set", 1'b1, wave_output)
		`CHK("force noflag", 1'b0, compare_flag)
		`CHK("pin source", 1'b1, wave_pin_sel)
		`CHK("ovf wclr", 1'b0, overflow_flag)
		act <= 2'h1;
		pulse(7'h10);
		tick(2);
		`CHK("force toggle", 1'b0, wave_output)
		pulse(7'h10);
		wm <= 2'h3;
		tick(3);
		`CHK("mode keeps out", 1'b1, wave_output)
		$display("test force done");
		cmp_d <= 8'h40;
		pulse(7'h20);
		tick(1);
		`CHK("buf view", 8'h40, compare_value)
		`CHK("active held", 8'h05, compare_active)
		cnt_d <= 8'hF0;
		pulse(7'h40);
		cs <= 3'h1;
		for (int i = 0; i < 40 && at_top !== 1'b1; i++) @(posedge mclk);
		tick(3);
		`CHK("buf loaded", 8'h40, compare_active)
		`CHK("fpwm ovf", 1'b1, overflow_flag)
		`CHK("fpwm ovf irq", 1'b1, overflow_irq)
		act <= 2'h2;
		pulse(7'h01);
		`CHK("ovf ack", 1'b0, overflow_flag)
		$display("test buffer done");
		// Counter runs from zero to the new compare value 0x40
		for (int i = 0; i < 100 && compare_flag !== 1'b1; i++) @(posedge mclk);
		`CHK("fpwm flag", 1'b1, compare_flag)
		`CHK("fpwm clear", 1'b0, wave_output)
		`CHK("irq again", 1'b1, compare_irq)
		pulse(7'h08);
		`CHK("flag wclr", 1'b0, compare_flag)
		cs <= 3'h0;
		wm <= 2'h1;
		cnt_d <= 8'hFD;
		cmp_d <= 8'h10;
		pulse(7'h60);
		cs <= 3'h1;
		for (int i = 0; i < 40 && at_top !== 1'b1; i++) @(posedge mclk);
		tick(3);
		`CHK("dual slope", 8'hFA, count_value)
		`CHK("buf at top", 8'h10, compare_active)
		$display("test pwm done");
		cs <= 3'h0;
		wm <= 2'h0;
		cnt_d <= 8'h20;
		pulse(7'h40);
		cs <= 3'h2;
		// Prescaler phase is free running, so nine or ten ticks fit in 80 cycles
		tick(80);
		`CHK("div8 count", 1'b1, count_value >= 8'h29 && count_value <= 8'h2A)
		cs <= 3'h0;
		cnt_d <= 8'h30;
		pulse(7'h40);
		cs <= 3'h7;
		ext_edges(3);
		`CHK("ext rise", 8'h33, count_value)
		cs <= 3'h6;
		ext_edges(1);
		`CHK("ext fall", 8'h34, count_value)
		$display("test tick source done");
		give_verdict;
	end
endmodule // testbench
bind tmr_core tmr_core_mon u_mon (.mclk(mclk), .rst(rst), .clock_select(clock_select),
	.wave_mode_sel(wave_mode_sel), .output_action_sel(output_action_sel), .count_wr(count_wr),
	.count_wdata(count_wdata), .force_compare(force_compare), .compare_flag_clr(compare_flag_clr),
	.compare_irq_ack(compare_irq_ack), .compare_irq_enable(compare_irq_enable),
	.global_irq_enable(global_irq_enable), .count_value(count_value), .compare_flag(compare_flag),
	.overflow_flag(overflow_flag), .compare_irq(compare_irq), .wave_output(wave_output),
	.wave_pin_sel(wave_pin_sel), .at_top(at_top));
